/* src/inrush_ovp_map.svh */
//------------------------------------------------------------------------------
// register map, field layout, reset values and timing counts
//------------------------------------------------------------------------------
// Purpose: constants of the inrush, overvoltage and light-load configuration block
// Assumes: 100 MHz system clock, 16-bit command codes, 8-bit registers
// Notes:   included by its bare name
//
// Functional notes
// - line-low flag window: 00 quarter cycle, 01 half cycle, 10 2 ms, 11 4 ms
// - after sag flag drops, wait 0..7 full line cycles, then raise inrush
// - rising overvoltage level is 1 V plus code times 0.492/128 V
// - falling overvoltage level uses its own code with the same relation
// - code 0x00 gives 1 V, 0x7F gives 1.488 V, about 3.844 mV a step
// - debounce overvoltage comparator: 120, 240, 480 or 640 ns by field
// - enter low power mode while measured input power is below threshold
// - after inrush asserts, wait 0..7 full line cycles before soft start
`ifndef INRUSH_OVP_MAP_SVH
`define INRUSH_OVP_MAP_SVH

// command codes
`define ADDR_SOFT_START_SETUP    16'hfe2d
`define ADDR_INRUSH_TIMING_SETUP 16'hfe2e
`define ADDR_OV_RISE_LEVEL       16'hfe2f
`define ADDR_OV_FALL_LEVEL       16'hfe30
`define ADDR_OV_FILTER_TIME      16'hfe31
`define ADDR_LIGHT_LOAD_LEVEL    16'hfe32

// field positions and writable masks
`define SS_DELAY_LSB             3
`define SS_DELAY_MSB             5
`define TIMER_SEL_LSB            3
`define TIMER_SEL_MSB            4
`define INRUSH_DLY_LSB           0
`define INRUSH_DLY_MSB           2
`define MASK_SOFT_START          8'h38
`define MASK_INRUSH_TIMING       8'h1f
`define MASK_OV_LEVEL            8'h7f
`define MASK_OV_FILTER           8'h03
`define MASK_LIGHT_LOAD          8'hff

// reset values
`define RST_SOFT_START           8'h00
`define RST_INRUSH_TIMING        8'h00
`define RST_OV_RISE              8'h00
`define RST_OV_FALL              8'h00
`define RST_OV_FILTER            8'h00
`define RST_LIGHT_LOAD           8'h00

// timing
`define CLK_PERIOD_NS            10
`define WIN_2MS_NS               2000000
`define WIN_4MS_NS               4000000
`define DEB_120_NS               120
`define DEB_240_NS               240
`define DEB_480_NS               480
`define DEB_640_NS               640
`define DEB_120_CYC              (`DEB_120_NS / `CLK_PERIOD_NS)
`define DEB_240_CYC              (`DEB_240_NS / `CLK_PERIOD_NS)
`define DEB_480_CYC              (`DEB_480_NS / `CLK_PERIOD_NS)
`define DEB_640_CYC              (`DEB_640_NS / `CLK_PERIOD_NS)

// overvoltage level in microvolts: 1 V + code * 15375/4 uV
`define OV_BASE_UV               21'h0f4240
`define OV_STEP_QUARTER_UV       15375

`endif

/* src/inrush_ovp_pkg.sv */
//------------------------------------------------------------------------------
// types of the inrush and overvoltage block
//------------------------------------------------------------------------------
// Purpose: state encoding shared by design files
// Assumes: nothing
// Notes:   one-hot codes
package inrush_ovp_pkg;

   typedef enum logic [3:0] {
      ST_SAG     = 4'h1,   // line sag present, inrush off
      ST_DELAY   = 4'h2,   // counting line cycles before inrush
      ST_INRUSH  = 4'h4,   // inrush on, counting cycles before soft start
      ST_RUN     = 4'h8    // soft start released
   } inrush_state_t;

endpackage : inrush_ovp_pkg

/* src/ovp_debounce.sv */
//------------------------------------------------------------------------------
// overvoltage comparator debounce filter
//------------------------------------------------------------------------------
// Purpose: pass a comparator level only after it has stood for the set time
// Assumes: comparator input synchronous to clk_sys
// Notes:   both edges are filtered alike
`timescale 1ns/10ps
`include "inrush_ovp_map.svh"

module ovp_debounce (
   input  wire logic       clk_sys,
   input  wire logic       rst_n,
   input  wire logic       compRaw,
   input  wire logic [1:0] filterSel,
   output logic            compFiltered
);

   logic [6:0] cnt_reg;
   logic [6:0] cnt_next;
   logic       filt_reg;
   logic       filt_next;
   logic [6:0] target;

   // cycles the raw level must hold, by field
   function automatic logic [6:0] debCycles(input logic [1:0] sel);
      case (sel)
         2'h0:    debCycles = 7'(`DEB_120_CYC);
         2'h1:    debCycles = 7'(`DEB_240_CYC);
         2'h2:    debCycles = 7'(`DEB_480_CYC);
         default: debCycles = 7'(`DEB_640_CYC);
      endcase
   endfunction : debCycles

   // restart count on agreement, flip after the set run of disagreement
   always_comb begin
      target    = debCycles(filterSel);
      cnt_next  = 7'h00;
      filt_next = filt_reg;
      if (compRaw != filt_reg) begin
         if (cnt_reg == target - 7'h01) begin
            filt_next = compRaw;
         end else begin
            cnt_next  = cnt_reg + 7'h01;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cnt_reg  <= 7'h00;
         filt_reg <= 1'b0;
      end else begin
         cnt_reg  <= cnt_next;
         filt_reg <= filt_next;
      end
   end

   assign compFiltered = filt_reg;

   // a change of the filtered level follows a full run of the set length
   deb_run_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      $changed(filt_reg) |-> ($past(cnt_reg) == $past(target) - 7'h01))
      else $error("debounce output changed before the set time");

endmodule : ovp_debounce

/* src/inrush_ovp_cfg.sv */
//------------------------------------------------------------------------------
// inrush, overvoltage and light-load configuration block
//------------------------------------------------------------------------------
// Purpose: configuration registers plus line-low timer, inrush sequencing,
//          overvoltage level selection and debounce, light-load detection
// Assumes: line cycle tick and half period come from the line measurement
// Notes:   register reads answer one cycle after the read strobe
`timescale 1ns/10ps
`include "inrush_ovp_map.svh"

module inrush_ovp_cfg #(
   parameter logic [19:0] WIN_2MS_CYC = 20'(`WIN_2MS_NS / `CLK_PERIOD_NS),
   parameter logic [19:0] WIN_4MS_CYC = 20'(`WIN_4MS_NS / `CLK_PERIOD_NS)
) (
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   input  wire logic        regWrEn,
   input  wire logic        regRdEn,
   input  wire logic [15:0] regAddr,
   input  wire logic [7:0]  regWrData,
   output logic      [7:0]  regRdData,
   output logic             regRdValid,
   input  wire logic        lineCycleTick,
   input  wire logic [19:0] lineHalfPeriod,
   input  wire logic        lineBelowLow,
   input  wire logic        line_sag_flag,
   input  wire logic        output_overvoltage_sense,
   input  wire logic [7:0]  inputPower,
   input  wire logic        inputPowerValid,
   output logic             line_voltage_low_flag,
   output logic             inrushOn,
   output logic             softStartGo,
   output logic      [6:0]  ovDacCode,
   output logic      [20:0] ovLevelUv,
   output logic             overvoltageFault,
   output logic             lowPowerMode
);

   //---------------------------------------------------------------------------
   // configuration registers
   //---------------------------------------------------------------------------
   logic [7:0] softStartSetup_reg, softStartSetup_next;
   logic [7:0] inrush_timing_setup_reg, inrush_timing_setup_next;
   logic [7:0] overvoltage_rise_level_reg, overvoltage_rise_level_next;
   logic [7:0] overvoltage_fall_level_reg, overvoltage_fall_level_next;
   logic [7:0] overvoltage_filter_time_reg, overvoltage_filter_time_next;
   logic [7:0] light_load_power_level_reg, light_load_power_level_next;
   logic [7:0] rdData_reg, rdData_next;
   logic       rdValid_reg;

   // masked write: unused bits stay zero
   function automatic logic [7:0] wr8(input logic [7:0] cur, input logic [7:0] mask,
                                      input logic hit, input logic [7:0] data);
      wr8 = hit ? (data & mask) : cur;
   endfunction : wr8

   // write decode and read mux
   always_comb begin
      softStartSetup_next          = wr8(softStartSetup_reg, `MASK_SOFT_START,
         regWrEn && regAddr == `ADDR_SOFT_START_SETUP, regWrData);
      inrush_timing_setup_next     = wr8(inrush_timing_setup_reg, `MASK_INRUSH_TIMING,
         regWrEn && regAddr == `ADDR_INRUSH_TIMING_SETUP, regWrData);
      overvoltage_rise_level_next  = wr8(overvoltage_rise_level_reg, `MASK_OV_LEVEL,
         regWrEn && regAddr == `ADDR_OV_RISE_LEVEL, regWrData);
      overvoltage_fall_level_next  = wr8(overvoltage_fall_level_reg, `MASK_OV_LEVEL,
         regWrEn && regAddr == `ADDR_OV_FALL_LEVEL, regWrData);
      overvoltage_filter_time_next = wr8(overvoltage_filter_time_reg, `MASK_OV_FILTER,
         regWrEn && regAddr == `ADDR_OV_FILTER_TIME, regWrData);
      light_load_power_level_next  = wr8(light_load_power_level_reg, `MASK_LIGHT_LOAD,
         regWrEn && regAddr == `ADDR_LIGHT_LOAD_LEVEL, regWrData);
      case (regAddr)
         `ADDR_SOFT_START_SETUP:    rdData_next = softStartSetup_reg;
         `ADDR_INRUSH_TIMING_SETUP: rdData_next = inrush_timing_setup_reg;
         `ADDR_OV_RISE_LEVEL:       rdData_next = overvoltage_rise_level_reg;
         `ADDR_OV_FALL_LEVEL:       rdData_next = overvoltage_fall_level_reg;
         `ADDR_OV_FILTER_TIME:      rdData_next = overvoltage_filter_time_reg;
         `ADDR_LIGHT_LOAD_LEVEL:    rdData_next = light_load_power_level_reg;
         default:                   rdData_next = 8'h00; // unmapped reads zero
      endcase
      if (!regRdEn) begin
         rdData_next = rdData_reg;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         softStartSetup_reg          <= `RST_SOFT_START;
         inrush_timing_setup_reg     <= `RST_INRUSH_TIMING;
         overvoltage_rise_level_reg  <= `RST_OV_RISE;
         overvoltage_fall_level_reg  <= `RST_OV_FALL;
         overvoltage_filter_time_reg <= `RST_OV_FILTER;
         light_load_power_level_reg  <= `RST_LIGHT_LOAD;
         rdData_reg                  <= 8'h00;
         rdValid_reg                 <= 1'b0;
      end else begin
         softStartSetup_reg          <= softStartSetup_next;
         inrush_timing_setup_reg     <= inrush_timing_setup_next;
         overvoltage_rise_level_reg  <= overvoltage_rise_level_next;
         overvoltage_fall_level_reg  <= overvoltage_fall_level_next;
         overvoltage_filter_time_reg <= overvoltage_filter_time_next;
         light_load_power_level_reg  <= light_load_power_level_next;
         rdData_reg                  <= rdData_next;
         rdValid_reg                 <= regRdEn;
      end
   end

   assign regRdData  = rdData_reg;
   assign regRdValid = rdValid_reg;

   //---------------------------------------------------------------------------
   // line-low measurement timer
   //---------------------------------------------------------------------------
   logic [19:0] lowCnt_reg, lowCnt_next;
   logic        lowFlag_reg, lowFlag_next;
   logic [19:0] window;

   // window length in clock cycles for the timer field
   function automatic logic [19:0] winCycles(input logic [1:0] sel, input logic [19:0] half,
                                             input logic [19:0] w2, input logic [19:0] w4);
      case (sel)
         2'h0:    winCycles = {1'b0, half[19:1]};
         2'h1:    winCycles = half;
         2'h2:    winCycles = w2;
         default: winCycles = w4;
      endcase
   endfunction : winCycles

   // flag sets once the line stays low for a whole window, clears on recovery
   always_comb begin
      window = winCycles(inrush_timing_setup_reg[`TIMER_SEL_MSB:`TIMER_SEL_LSB],
                         lineHalfPeriod, WIN_2MS_CYC, WIN_4MS_CYC);
      lowCnt_next  = 20'h00000;
      lowFlag_next = 1'b0;
      if (lineBelowLow) begin
         if (lowFlag_reg || lowCnt_reg + 20'h00001 >= window) begin
            lowFlag_next = 1'b1;
            lowCnt_next  = lowCnt_reg;
         end else begin
            lowCnt_next  = lowCnt_reg + 20'h00001;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         lowCnt_reg  <= 20'h00000;
         lowFlag_reg <= 1'b0;
      end else begin
         lowCnt_reg  <= lowCnt_next;
         lowFlag_reg <= lowFlag_next;
      end
   end

   assign line_voltage_low_flag = lowFlag_reg;

   //---------------------------------------------------------------------------
   // inrush and soft start sequencing
   //---------------------------------------------------------------------------
   inrush_ovp_pkg::inrush_state_t state_reg, state_next;
   logic [2:0] cyc_reg, cyc_next;
   logic       inrush_reg, inrush_next;
   logic       ssGo_reg, ssGo_next;

   // sag resets the sequence; each wait counts full line cycles
   always_comb begin
      state_next = state_reg;
      cyc_next   = cyc_reg;
      case (state_reg)
         inrush_ovp_pkg::ST_SAG: begin
            cyc_next = 3'h0;
            if (!line_sag_flag) begin
               state_next = inrush_ovp_pkg::ST_DELAY;
            end
         end
         inrush_ovp_pkg::ST_DELAY: begin
            if (cyc_reg == inrush_timing_setup_reg[`INRUSH_DLY_MSB:`INRUSH_DLY_LSB]) begin
               state_next = inrush_ovp_pkg::ST_INRUSH;
               cyc_next   = 3'h0;
            end else if (lineCycleTick) begin
               cyc_next = cyc_reg + 3'h1;
            end
         end
         inrush_ovp_pkg::ST_INRUSH: begin
            if (cyc_reg == softStartSetup_reg[`SS_DELAY_MSB:`SS_DELAY_LSB]) begin
               state_next = inrush_ovp_pkg::ST_RUN;
            end else if (lineCycleTick) begin
               cyc_next = cyc_reg + 3'h1;
            end
         end
         inrush_ovp_pkg::ST_RUN: begin
            cyc_next = 3'h0;
         end
         default: begin
            state_next = inrush_ovp_pkg::ST_SAG;
            cyc_next   = 3'h0;
         end
      endcase
      if (line_sag_flag) begin
         state_next = inrush_ovp_pkg::ST_SAG;
      end
      inrush_next = (state_next == inrush_ovp_pkg::ST_INRUSH) ||
                    (state_next == inrush_ovp_pkg::ST_RUN);
      ssGo_next   = (state_next == inrush_ovp_pkg::ST_RUN);
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_reg  <= inrush_ovp_pkg::ST_SAG;
         cyc_reg    <= 3'h0;
         inrush_reg <= 1'b0;
         ssGo_reg   <= 1'b0;
      end else begin
         state_reg  <= state_next;
         cyc_reg    <= cyc_next;
         inrush_reg <= inrush_next;
         ssGo_reg   <= ssGo_next;
      end
   end

   assign inrushOn    = inrush_reg;
   assign softStartGo = ssGo_reg;

   //---------------------------------------------------------------------------
   // overvoltage levels, debounce, light load
   //---------------------------------------------------------------------------
   logic [6:0]  dac_reg, dac_next;
   logic [20:0] uv_reg, uv_next;
   logic        lowPwr_reg, lowPwr_next;
   logic        ovFilt;

   // level in microvolts: 1 V + code * 3843.75 uV
   function automatic logic [20:0] levelUv(input logic [6:0] code);
      logic [20:0] step;
      step    = 21'((21'(code) * 21'(`OV_STEP_QUARTER_UV)) >> 2);
      levelUv = `OV_BASE_UV + step;
   endfunction : levelUv

   ovp_debounce u_deb (
      .clk_sys      (clk_sys),
      .rst_n        (rst_n),
      .compRaw      (output_overvoltage_sense),
      .filterSel    (overvoltage_filter_time_reg[1:0]),
      .compFiltered (ovFilt)
   );

   // trip at rise level, release at fall level once tripped
   always_comb begin
      dac_next = ovFilt ? overvoltage_fall_level_reg[6:0]
                        : overvoltage_rise_level_reg[6:0];
      uv_next  = levelUv(dac_next);
      lowPwr_next = lowPwr_reg;
      if (inputPowerValid) begin
         lowPwr_next = (inputPower < light_load_power_level_reg);
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         dac_reg    <= 7'h00;
         uv_reg     <= `OV_BASE_UV;
         lowPwr_reg <= 1'b0;
      end else begin
         dac_reg    <= dac_next;
         uv_reg     <= uv_next;
         lowPwr_reg <= lowPwr_next;
      end
   end

   assign ovDacCode        = dac_reg;
   assign ovLevelUv        = uv_reg;
   assign overvoltageFault = ovFilt;
   assign lowPowerMode     = lowPwr_reg;

   //---------------------------------------------------------------------------
   // assertions
   //---------------------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   lowflag_window_a: assert property ($rose(lowFlag_reg) |-> $past(lineBelowLow) &&
      ($past(lowCnt_reg) + 20'h00001 >= $past(window)))
      else $error("line-low flag set before the window elapsed");
   inrush_delay_a: assert property ($rose(inrush_reg) |->
      $past(state_reg) == inrush_ovp_pkg::ST_DELAY &&
      $past(cyc_reg) == $past(inrush_timing_setup_reg[2:0]))
      else $error("inrush raised without the set line-cycle delay");
   rise_level_a: assert property (!ovFilt ##1 !ovFilt |->
      dac_reg == $past(overvoltage_rise_level_reg[6:0]))
      else $error("rise level not applied while untripped");
   fall_level_a: assert property (ovFilt ##1 ovFilt |->
      dac_reg == $past(overvoltage_fall_level_reg[6:0]))
      else $error("fall level not applied while tripped");
   level_scale_a: assert property ((dac_reg == 7'h3f |-> uv_reg == 21'd1242156) and
      (dac_reg == 7'h7f |-> uv_reg == 21'd1488156) and
      (dac_reg == 7'h00 |-> uv_reg == 21'd1000000))
      else $error("overvoltage level scaling wrong");
   low_power_a: assert property (inputPowerValid |=>
      lowPwr_reg == ($past(inputPower) < $past(light_load_power_level_reg)))
      else $error("low power mode does not follow threshold");
   soft_delay_a: assert property ($rose(ssGo_reg) |-> inrush_reg &&
      $past(cyc_reg) == $past(softStartSetup_reg[5:3]))
      else $error("soft start released without the set delay");
   sag_abort_a: assert property (line_sag_flag |=> !inrush_reg && !ssGo_reg)
      else $error("inrush held during line sag");
   unused_zero_a: assert property (regRdValid |->
      (softStartSetup_reg & ~`MASK_SOFT_START) == 8'h00 &&
      (inrush_timing_setup_reg & ~`MASK_INRUSH_TIMING) == 8'h00 &&
      overvoltage_rise_level_reg[7] == 1'b0 && overvoltage_fall_level_reg[7] == 1'b0 &&
      (overvoltage_filter_time_reg & ~`MASK_OV_FILTER) == 8'h00)
      else $error("unused bits not zero");

   inrush_seen_c:  cover property ($rose(inrush_reg));
   soft_seen_c:    cover property ($rose(ssGo_reg));
   ov_trip_c:      cover property ($rose(ovFilt) ##[1:200] $fell(ovFilt));
   low_power_c:    cover property ($rose(lowPwr_reg));

endmodule : inrush_ovp_cfg

/* tb/boost_stage_model.sv */
//------------------------------------------------------------------------------
// boost stage with overvoltage sense comparator
//------------------------------------------------------------------------------
// Purpose: far-side model, output voltage compared with the threshold dac
// Assumes: comparator output settles within one clock
// Notes:   output voltage is set by the bench in microvolts
`timescale 1ns/10ps

module boost_stage_model (
   input  wire logic        clk_sys,
   input  wire logic [6:0]  ovDacCode,
   input  wire logic [20:0] voutUv,
   output logic             output_overvoltage_sense
);
   initial output_overvoltage_sense = 1'b0;
   // comparator output resampled each clock, level in quarter microvolts
   always @(posedge clk_sys) begin
      output_overvoltage_sense <= 24'(voutUv) * 24'd4 > 24'd4000000 + 24'(ovDacCode) * 24'd15375;
   end
endmodule : boost_stage_model

/* tb/testbench.sv */
//------------------------------------------------------------------------------
// testbench of the inrush and overvoltage configuration block
//------------------------------------------------------------------------------
// Purpose: register map, line-low timer, inrush sequence, overvoltage, low power
// Assumes: windows shortened to 20 and 40 cycles
// Notes:   inputs change on the falling edge
`timescale 1ns/10ps
`include "inrush_ovp_map.svh"

module testbench;
   logic        clk_sys, rst_n, regWrEn, regRdEn, regRdValid, lineCycleTick;
   logic [15:0] regAddr;
   logic [7:0]  regWrData, regRdData, inputPower, rdv;
   logic [19:0] lineHalfPeriod;
   logic        lineBelowLow, line_sag_flag, ovSense, inputPowerValid;
   logic        line_voltage_low_flag, inrushOn, softStartGo, overvoltageFault;
   logic        lowPowerMode;
   logic [6:0]  ovDacCode;
   logic [20:0] ovLevelUv, voutUv;
   int          n_fail, n_checks, seed, cnt, ti, tk, thr, p;
   int          masks[7] = '{8'h38, 8'h1f, 8'h7f, 8'h7f, 8'h03, 8'hff, 8'h00};
   int          wins[4]  = '{4, 8, 20, 40};
   int          debs[4]  = '{12, 24, 48, 64};
   int          codes[3] = '{8'h00, 8'h3f, 8'h7f};

   inrush_ovp_cfg #(.WIN_2MS_CYC(20'd20), .WIN_4MS_CYC(20'd40)) inrush_ovp_cfg_inst (
      .clk_sys(clk_sys), .rst_n(rst_n), .regWrEn(regWrEn), .regRdEn(regRdEn),
      .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
      .regRdValid(regRdValid), .lineCycleTick(lineCycleTick),
      .lineHalfPeriod(lineHalfPeriod), .lineBelowLow(lineBelowLow),
      .line_sag_flag(line_sag_flag), .output_overvoltage_sense(ovSense),
      .inputPower(inputPower), .inputPowerValid(inputPowerValid),
      .line_voltage_low_flag(line_voltage_low_flag), .inrushOn(inrushOn),
      .softStartGo(softStartGo), .ovDacCode(ovDacCode), .ovLevelUv(ovLevelUv),
      .overvoltageFault(overvoltageFault), .lowPowerMode(lowPowerMode));

   boost_stage_model boost_stage_model_inst (
      .clk_sys(clk_sys), .ovDacCode(ovDacCode), .voutUv(voutUv),
      .output_overvoltage_sense(ovSense));

   //---------------------------------------------------------------------------
   // clock and shared tasks
   //---------------------------------------------------------------------------
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
      end
   endtask : chk

   task automatic wr(logic [15:0] a, logic [7:0] d);
      @(negedge clk_sys) {regWrEn, regAddr, regWrData} = {1'b1, a, d};
      @(negedge clk_sys) regWrEn = 1'b0;
   endtask : wr

   task automatic rd(logic [15:0] a);
      @(negedge clk_sys) {regRdEn, regAddr} = {1'b1, a};
      @(negedge clk_sys) regRdEn = 1'b0;
      chk("rd_valid", regRdValid, 1);
      rdv = regRdData;
   endtask : rd

   task automatic give_verdict;
      $display("checks %0d failures %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : give_verdict

   // counts cycles until a watched flag reaches a level, bounded
   task automatic wait_lvl(ref logic s, input logic v, output int c);
      for (c = 1; c < 300 && s !== v; c++) @(negedge clk_sys);
      if (c >= 300) begin
         chk("wait_bound", 0, 1);
         give_verdict();
      end
   endtask : wait_lvl

   //---------------------------------------------------------------------------
   // main sequence
   //---------------------------------------------------------------------------
   initial begin
      {rst_n, regWrEn, regRdEn, lineCycleTick, lineBelowLow, inputPowerValid} = '0;
      {regAddr, regWrData, inputPower} = '0;
      {n_fail, n_checks, seed} = {32'd0, 32'd0, 32'd93675};
      lineHalfPeriod = 20'd8;
      line_sag_flag  = 1'b1;
      voutUv         = 21'd900000;
      repeat (10) @(negedge clk_sys);
      rst_n = 1'b1;
      // reset values, writable masks, unmapped code
      for (int i = 0; i < 7; i++) begin
         rd(16'hfe2d + 16'(i));
         chk("reg_reset", rdv, 0);
         wr(16'hfe2d + 16'(i), 8'hff);
         rd(16'hfe2d + 16'(i));
         chk("reg_mask", rdv, masks[i]);
      end
      // threshold levels from the rising code
      for (int i = 0; i < 3; i++) begin
         wr(`ADDR_OV_RISE_LEVEL, 8'(codes[i]));
         repeat (2) @(negedge clk_sys);
         chk("dac_code", ovDacCode, codes[i]);
         chk("level_uv", ovLevelUv, (4000000 + codes[i] * 15375) / 4);
      end
      // debounce times with rise and fall hysteresis
      wr(`ADDR_OV_RISE_LEVEL, 8'h40);
      wr(`ADDR_OV_FALL_LEVEL, 8'h10);
      for (int s = 0; s < 4; s++) begin
         wr(`ADDR_OV_FILTER_TIME, 8'(s));
         @(negedge clk_sys) voutUv = 21'd1500000;
         wait_lvl(overvoltageFault, 1'b1, cnt);
         chk("deb_rise", cnt >= debs[s] && cnt <= debs[s] + 3, 1);
         // threshold code follows the filtered level one clock later
         @(negedge clk_sys);
         chk("fall_code", ovDacCode, 7'h10);
         voutUv = 21'd1200000;
         repeat (80) @(negedge clk_sys);
         chk("hold_fault", overvoltageFault, 1);
         voutUv = 21'd900000;
         wait_lvl(overvoltageFault, 1'b0, cnt);
         chk("deb_fall", cnt >= debs[s] && cnt <= debs[s] + 3, 1);
      end
      // line-low window for each timer setting
      for (int s = 0; s < 4; s++) begin
         wr(`ADDR_INRUSH_TIMING_SETUP, 8'(s << 3));
         @(negedge clk_sys) lineBelowLow = 1'b1;
         wait_lvl(line_voltage_low_flag, 1'b1, cnt);
         chk("low_window", cnt >= wins[s] && cnt <= wins[s] + 2, 1);
         lineBelowLow = 1'b0;
         repeat (2) @(negedge clk_sys);
         chk("low_clear", line_voltage_low_flag, 0);
      end
      // inrush and soft start delays in line cycles
      for (int n = 0; n < 8; n += 3) begin
         wr(`ADDR_INRUSH_TIMING_SETUP, 8'(n));
         wr(`ADDR_SOFT_START_SETUP, 8'(((n + 2) % 8) << 3));
         @(negedge clk_sys) line_sag_flag = 1'b0;
         ti = -1;
         tk = 0;
         for (int c = 1; c < 400 && !softStartGo; c++) begin
            @(negedge clk_sys) lineCycleTick = (c % 6 == 0);
            tk += lineCycleTick;
            if (inrushOn === 1'b1 && ti < 0) ti = tk;
         end
         // a sequence that never releases soft start ends the run
         if (softStartGo !== 1'b1) begin
            chk("start_bound", 0, 1);
            give_verdict();
         end
         chk("inrush_ticks", ti, n);
         chk("start_ticks", tk - ti, (n + 2) % 8);
         {lineCycleTick, line_sag_flag} = 2'b01;
         repeat (3) @(negedge clk_sys);
         chk("sag_restart", {inrushOn, softStartGo}, 0);
      end
      // low power mode against random power readings
      thr = $random(seed) & 8'hff;
      wr(`ADDR_LIGHT_LOAD_LEVEL, 8'(thr));
      repeat (16) begin
         p = $random(seed) & 8'hff;
         @(negedge clk_sys) {inputPowerValid, inputPower} = {1'b1, 8'(p)};
         @(negedge clk_sys) inputPowerValid = 1'b0;
         @(negedge clk_sys);
         chk("low_power", lowPowerMode, p < thr);
      end
      give_verdict();
   end
endmodule : testbench
